//--- hw/int_sched_pkg.sv
`default_nettype none

package int_sched_pkg;

    // ************************************************************
    // Register map (byte addresses on the Avalon-MM slave)
    // ************************************************************
    localparam logic [4:0] DESC_CTRL_OFFSET = 5'h00;
    localparam logic [4:0] DESC_POLL_OFFSET = 5'h04;
    localparam logic [4:0] PROGRESS_OFFSET  = 5'h08;
    localparam logic [4:0] STATUS_OFFSET    = 5'h0C;
    localparam logic [4:0] MASK_OFFSET      = 5'h10;

    // ************************************************************
    // Descriptor control word fields
    // ************************************************************
    localparam int MULT_LSB   = 29;
    localparam int MULT_MSB   = 30;
    localparam int MAXPKT_LSB = 18;
    localparam int MAXPKT_MSB = 28;
    localparam int COUNT_LSB  = 3;
    localparam int COUNT_MSB  = 17;
    localparam int VALID_BIT  = 0;

    // ************************************************************
    // Polling word fields
    // ************************************************************
    localparam int INTERVAL_LSB = 3;
    localparam int INTERVAL_MSB = 7;
    localparam int SELMASK_LSB  = 8;
    localparam int SELMASK_MSB  = 15;

    // ************************************************************
    // Progress word and interrupt bits
    // ************************************************************
    localparam int BUSY_BIT    = 31;
    localparam int DONE_EVENT  = 0;
    localparam int ERROR_EVENT = 1;

    // ************************************************************
    // Reset values and unmapped read value
    // ************************************************************
    localparam logic [1:0]  MULT_RESET    = 2'h1;
    localparam logic [10:0] MAXPKT_RESET  = 11'h000;
    localparam logic [14:0] COUNT_RESET   = 15'h0000;
    localparam logic [4:0]  INTERVAL_RESET = 5'h00;
    localparam logic [7:0]  SELMASK_RESET = 8'hFF;
    localparam logic [1:0]  MASK_RESET    = 2'h0;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [3:0] {
        IDLE     = 4'h1,
        WAIT_UF  = 4'h2,
        ISSUE    = 4'h4,
        WAIT_PKT = 4'h8
    } seq_state_type;

endpackage

`default_nettype wire

//--- hw/poll_gate.sv
`timescale 1ns/1ps
`default_nettype none

module poll_gate (
    input  wire logic [2:0] uframe,
    input  wire logic [4:0] frame,
    input  wire logic [4:0] interval,
    input  wire logic [7:0] selMask,
    output logic            service
);

    // ************************************************************
    // Interval decode
    // ************************************************************
    // The highest set bit of the interval picks 2 to 32 ms; the bits below
    // it are the phase, so the mask is every bit up to that highest one.
    logic [4:0] phaseMask;

    always_comb begin
        phaseMask = interval | (interval >> 1) | (interval >> 2) | (interval >> 3) | (interval >> 4);
        // R6 R7 R8
        service = selMask[uframe] && ((frame & phaseMask) == interval);
    end

endmodule

`default_nettype wire

//--- hw/hs_interrupt_descriptor_sched.sv
// Contract
// R1: The packet multiplier gives how many packets may be issued to the endpoint in one serviced microframe.
// R2: Software programs the multiplier to 01b normally, 10b or 11b if needed, and never 00b.
// R3: Every packet issued is no longer than the maximum packet length.
// R4: The fifteen-bit transfer byte count is the total payload of the descriptor.
// R5: Software sets the valid bit to start, and the controller clears it at completion or on a fatal error.
// R6: The endpoint is serviced only in microframes whose select-mask bit is set.
// R7: A nonzero frame interval field selects 2, 4, 8, 16 or 32 ms with one serviced microframe per interval;
// the code services every microframe of the matching frame whose select-mask bit is set.
// R8: The polling period is two to the b minus one microframes, with the interval field zero at 1 ms or less.
`timescale 1ns/1ps
`default_nettype none

module hs_interrupt_descriptor_sched (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        microframeTick,
    output logic             pktReq,
    output logic [10:0]      pktLen,
    input  wire logic        pktDone,
    input  wire logic [10:0] pktActual,
    input  wire logic        pktFatal,
    output logic             irq
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        int_sched_pkg::seq_state_type seq;
        logic [1:0]  mult;
        logic [10:0] maxPkt;
        logic [14:0] total;
        logic        valid;
        logic [4:0]  interval;
        logic [7:0]  selMask;
        logic [14:0] remaining;
        logic [14:0] doneBytes;
        logic [1:0]  pktsLeft;
        logic [2:0]  uframe;
        logic [4:0]  frame;
        logic        tickSeen;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic        irq;
        logic        waitReq;
        logic [31:0] readData;
        logic        pktReq;
        logic [10:0] pktLen;
    } regs_type;

    regs_type r;
    regs_type next_r;
    logic     service;

    function automatic logic [10:0] packet_length(input logic [10:0] maxPkt, input logic [14:0] remaining);
        packet_length = (remaining < {4'h0, maxPkt}) ? remaining[10:0] : maxPkt;
    endfunction

    poll_gate gate (
        .uframe   (r.uframe),
        .frame    (r.frame),
        .interval (r.interval),
        .selMask  (r.selMask),
        .service  (service)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    logic        accept;
    logic [1:0]  events;
    logic [10:0] got;
    logic [14:0] left;

    always_comb begin
        next_r = r;
        events = 2'h0;
        accept = (avs_read || avs_write) && r.waitReq;
        got    = (pktActual > r.pktLen) ? r.pktLen : pktActual;
        left   = r.remaining - {4'h0, got};

        next_r.tickSeen = microframeTick;
        if (microframeTick) begin
            next_r.uframe = r.uframe + 3'h1;
            if (r.uframe == 3'h7) begin
                next_r.frame = r.frame + 5'h01;
            end
        end

        unique case (r.seq)
            int_sched_pkg::IDLE: begin
                if (r.valid) begin
                    next_r.remaining = r.total; // R4
                    next_r.doneBytes = 15'h0000;
                    next_r.seq       = int_sched_pkg::WAIT_UF;
                end
            end
            int_sched_pkg::WAIT_UF: begin
                if (r.remaining == 15'h0000) begin
                    next_r.valid  = 1'b0; // R5
                    events[int_sched_pkg::DONE_EVENT] = 1'b1;
                    next_r.seq    = int_sched_pkg::IDLE;
                end else if (r.tickSeen && service) begin // R6 R7
                    // A multiplier of zero is undefined; one packet is the safe reading.
                    next_r.pktsLeft = (r.mult == 2'h0) ? 2'h1 : r.mult; // R1 R2
                    next_r.seq      = int_sched_pkg::ISSUE;
                end
            end
            int_sched_pkg::ISSUE: begin
                next_r.pktReq = 1'b1;
                next_r.pktLen = packet_length(r.maxPkt, r.remaining); // R3
                next_r.seq    = int_sched_pkg::WAIT_PKT;
            end
            int_sched_pkg::WAIT_PKT: begin
                if (pktDone) begin
                    next_r.pktReq    = 1'b0;
                    next_r.doneBytes = r.doneBytes + {4'h0, got};
                    next_r.remaining = left;
                    next_r.pktsLeft  = r.pktsLeft - 2'h1;
                    if (pktFatal) begin
                        next_r.valid = 1'b0; // R5
                        events[int_sched_pkg::ERROR_EVENT] = 1'b1;
                        next_r.seq   = int_sched_pkg::IDLE;
                    end else if (left == 15'h0000 || got < r.pktLen) begin
                        // A short packet ends the transfer as in any interrupt pipe.
                        next_r.valid = 1'b0; // R5
                        events[int_sched_pkg::DONE_EVENT] = 1'b1;
                        next_r.seq   = int_sched_pkg::IDLE;
                    end else if (r.pktsLeft == 2'h1) begin // R1
                        next_r.seq = int_sched_pkg::WAIT_UF;
                    end else begin
                        next_r.seq = int_sched_pkg::ISSUE;
                    end
                end
            end
        endcase

        // ************************************************************
        // Avalon-MM slave
        // ************************************************************
        // One wait cycle on every access keeps read data registered.
        next_r.waitReq = 1'b1;
        if (accept) begin
            next_r.waitReq  = 1'b0;
            next_r.readData = int_sched_pkg::UNMAPPED_READ;
            if (avs_read) begin
                unique case (avs_address)
                    int_sched_pkg::DESC_CTRL_OFFSET: begin
                        next_r.readData[int_sched_pkg::MULT_MSB:int_sched_pkg::MULT_LSB]     = r.mult;
                        next_r.readData[int_sched_pkg::MAXPKT_MSB:int_sched_pkg::MAXPKT_LSB] = r.maxPkt;
                        next_r.readData[int_sched_pkg::COUNT_MSB:int_sched_pkg::COUNT_LSB]   = r.total;
                        next_r.readData[int_sched_pkg::VALID_BIT]                            = r.valid;
                    end
                    int_sched_pkg::DESC_POLL_OFFSET: begin
                        next_r.readData[int_sched_pkg::INTERVAL_MSB:int_sched_pkg::INTERVAL_LSB] = r.interval;
                        next_r.readData[int_sched_pkg::SELMASK_MSB:int_sched_pkg::SELMASK_LSB]   = r.selMask;
                    end
                    int_sched_pkg::PROGRESS_OFFSET: begin
                        next_r.readData[14:0] = r.doneBytes;
                        next_r.readData[int_sched_pkg::BUSY_BIT] = (r.seq != int_sched_pkg::IDLE);
                    end
                    int_sched_pkg::STATUS_OFFSET: begin
                        next_r.readData[1:0] = r.status;
                        next_r.status        = 2'h0;
                    end
                    int_sched_pkg::MASK_OFFSET: begin
                        next_r.readData[1:0] = r.mask;
                    end
                    default: begin
                        next_r.readData = int_sched_pkg::UNMAPPED_READ;
                    end
                endcase
            end else begin
                unique case (avs_address)
                    int_sched_pkg::DESC_CTRL_OFFSET: begin
                        // The control word is frozen while the descriptor runs.
                        if (r.seq == int_sched_pkg::IDLE) begin
                            if (avs_byteenable[3]) begin
                                next_r.mult = avs_writedata[int_sched_pkg::MULT_MSB:int_sched_pkg::MULT_LSB];
                            end
                            if (avs_byteenable[3] && avs_byteenable[2]) begin
                                next_r.maxPkt = avs_writedata[int_sched_pkg::MAXPKT_MSB:int_sched_pkg::MAXPKT_LSB];
                            end
                            if (avs_byteenable[2] && avs_byteenable[1] && avs_byteenable[0]) begin
                                next_r.total = avs_writedata[int_sched_pkg::COUNT_MSB:int_sched_pkg::COUNT_LSB];
                            end
                            if (avs_byteenable[0]) begin
                                next_r.valid = avs_writedata[int_sched_pkg::VALID_BIT]; // R5
                            end
                        end
                    end
                    int_sched_pkg::DESC_POLL_OFFSET: begin
                        if (avs_byteenable[0]) begin
                            next_r.interval = avs_writedata[int_sched_pkg::INTERVAL_MSB:int_sched_pkg::INTERVAL_LSB];
                        end
                        if (avs_byteenable[1]) begin
                            next_r.selMask = avs_writedata[int_sched_pkg::SELMASK_MSB:int_sched_pkg::SELMASK_LSB];
                        end
                    end
                    int_sched_pkg::MASK_OFFSET: begin
                        if (avs_byteenable[0]) begin
                            next_r.mask = avs_writedata[1:0];
                        end
                    end
                    default: begin
                        next_r.mask = r.mask;
                    end
                endcase
            end
        end

        // A new event outranks a clearing read in the same cycle.
        next_r.status = next_r.status | events;
        next_r.irq    = |(next_r.status & next_r.mask);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r          <= '0;
            r.seq      <= int_sched_pkg::IDLE;
            r.mult     <= int_sched_pkg::MULT_RESET;
            r.maxPkt   <= int_sched_pkg::MAXPKT_RESET;
            r.total    <= int_sched_pkg::COUNT_RESET;
            r.interval <= int_sched_pkg::INTERVAL_RESET;
            r.selMask  <= int_sched_pkg::SELMASK_RESET;
            r.mask     <= int_sched_pkg::MASK_RESET;
            r.waitReq  <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign avs_readdata    = r.readData;
    assign avs_waitrequest = r.waitReq;
    assign pktReq          = r.pktReq;
    assign pktLen          = r.pktLen;
    assign irq             = r.irq;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence packetIssued;
        r.seq == int_sched_pkg::ISSUE ##1 pktReq;
    endsequence

    chk_packet_length_cap: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
        packetIssued |-> (pktLen <= r.maxPkt) && ({4'h0, pktLen} <= r.remaining))
        else $error("Packet longer than allowed.");

    chk_packet_count_cap: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
        (r.seq == int_sched_pkg::WAIT_UF && next_r.seq == int_sched_pkg::ISSUE)
            |=> (r.pktsLeft == ((r.mult == 2'h0) ? 2'h1 : r.mult)))
        else $error("Packet budget differs from multiplier.");

    chk_service_mask_gate: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
        (r.seq == int_sched_pkg::WAIT_UF && next_r.seq == int_sched_pkg::ISSUE)
            |-> r.tickSeen && r.selMask[r.uframe])
        else $error("Service outside a selected microframe.");

    chk_interval_phase: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7 R8
        (r.seq == int_sched_pkg::WAIT_UF && next_r.seq == int_sched_pkg::ISSUE && r.interval[4])
            |-> r.frame == r.interval)
        else $error("Service outside the 32 ms phase.");

    chk_valid_start: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4 R5
        (r.seq == int_sched_pkg::IDLE && r.valid) |=> r.remaining == $past(r.total) ##0 r.seq == int_sched_pkg::WAIT_UF)
        else $error("Valid descriptor not started with its byte count.");

    chk_fatal_clears_valid: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
        (r.seq == int_sched_pkg::WAIT_PKT && pktDone && pktFatal)
            |=> !r.valid && r.status[int_sched_pkg::ERROR_EVENT] && r.seq == int_sched_pkg::IDLE)
        else $error("Fatal error left descriptor active.");

    chk_done_clears_valid: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
        ($fell(r.valid) && !$past(pktFatal)) |-> r.status[int_sched_pkg::DONE_EVENT] || $past(avs_write))
        else $error("Completion without done event.");

    chk_bytes_bounded: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
        (r.seq != int_sched_pkg::IDLE) |-> (r.doneBytes + r.remaining == r.total))
        else $error("Transferred and remaining bytes disagree with total.");

    chk_request_holds: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
        (pktReq && !pktDone) |=> pktReq && $stable(pktLen))
        else $error("Packet request dropped or length changed before done.");

    chk_idle_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
        (r.seq == int_sched_pkg::IDLE) |-> !pktReq)
        else $error("Packet requested with no active descriptor.");

    chk_bus_answer: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("Bus answer not one cycle after request.");

endmodule

`default_nettype wire

//--- bench/endpoint_model.sv
`timescale 1ns/1ps
`default_nettype none

module endpoint_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        pktReq,
    input  wire logic [10:0] pktLen,
    input  wire logic [1:0]  delay,
    input  wire logic [10:0] shortBy,
    input  wire logic        fatal,
    output logic             pktDone,
    output logic [10:0]      pktActual,
    output logic             pktFatal
);
    // ****************************************
    // Endpoint answering one packet per request
    // ****************************************
    int          waitLeft;
    logic        served;
    logic [10:0] lastActual;
    logic        answer;

    assign answer = pktReq && !served && (waitLeft == 0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waitLeft <= 0;
            served <= 1'b0;
            lastActual <= 11'h000;
            pktDone <= 1'b0;
            pktFatal <= 1'b0;
            pktActual <= 11'h7FF;
        end else begin
            // Between answers the count shows the inverse, so a stale value is never mistaken for fresh.
            pktDone <= answer;
            pktFatal <= answer && fatal;
            pktActual <= answer ? pktLen - shortBy : ~lastActual;
            if (answer) begin
                lastActual <= pktLen - shortBy;
            end
            if (!pktReq) begin
                served <= 1'b0;
                waitLeft <= int'(delay);
            end else if (!served && waitLeft > 0) begin
                waitLeft <= waitLeft - 1;
            end else if (!served) begin
                served <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

//--- bench/hs_interrupt_descriptor_sched_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module hs_interrupt_descriptor_sched_tb_top;
    // ****************************************
    // Signals and reference model state
    // ****************************************
    logic        ref_clk;
    logic        rst_n = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        microframeTick = 1'b0;
    logic        pktReq;
    logic [10:0] pktLen;
    logic        pktDone;
    logic [10:0] pktActual;
    logic        pktFatal;
    logic        irq;
    logic [1:0]  delay = 2'h0;
    logic [10:0] shortBy = 11'h000;
    logic        fatal = 1'b0;
    logic        reqSeen = 1'b0;
    logic [31:0] rd;
    logic [31:0] seed = 32'h00010EB4;
    int          fails = 0;
    int          compares = 0;
    int          cycles = 0;
    int          ticks = 0;
    int          mRem = 0, mMax = 0, mMult = 0, mSel = 0, mInt = 0, ufPkts = 0, maxPkts = 0, mMask = 0;
    int          intTab [9] = '{0, 0, 0, 0, 1, 3, 5, 9, 17};
    int          selTab [9] = '{8'hFF, 8'hAA, 8'h55, 8'h11, 8'h08, 8'h04, 8'h20, 8'h01, 8'h80};

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    hs_interrupt_descriptor_sched u_hs_interrupt_descriptor_sched (
        .ref_clk         (ref_clk),
        .rst_n           (rst_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (4'hF),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .microframeTick  (microframeTick),
        .pktReq          (pktReq),
        .pktLen          (pktLen),
        .pktDone         (pktDone),
        .pktActual       (pktActual),
        .pktFatal        (pktFatal),
        .irq             (irq)
    );

    endpoint_model u_endpoint_model (
        .clk       (ref_clk),
        .rst_n     (rst_n),
        .pktReq    (pktReq),
        .pktLen    (pktLen),
        .delay     (delay),
        .shortBy   (shortBy),
        .fatal     (fatal),
        .pktDone   (pktDone),
        .pktActual (pktActual),
        .pktFatal  (pktFatal)
    );

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic int smear(input int v);
        return v | (v >> 1) | (v >> 2) | (v >> 3) | (v >> 4);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        compares++;
        if (seen !== expected) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Entered just after a rising edge; the request holds until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic run_xfer(input int mult, input int maxp, input int count, input int intv,
                            input int sel, input int expProg, input int expStat);
        mMult = mult;
        mMax = maxp;
        mRem = count;
        mSel = sel;
        mInt = intv;
        maxPkts = 0;
        delay <= seed[1:0];
        bus(1'b1, int_sched_pkg::DESC_POLL_OFFSET, 32'((sel << 8) | (intv << 3)));
        bus(1'b1, int_sched_pkg::DESC_CTRL_OFFSET, 32'((mult << 29) | (maxp << 18) | (count << 3) | 1));
        rd = 32'h00000001;
        while (rd[0] !== 1'b0) bus(1'b0, int_sched_pkg::DESC_CTRL_OFFSET, 32'h00000000);
        bus(1'b0, int_sched_pkg::PROGRESS_OFFSET, 32'h00000000);
        if (expProg >= 0) check(rd, 32'(expProg));
        if (expProg == count) check(32'(maxPkts), 32'(mult));
        check(32'(irq), 32'((expStat & mMask) != 0));
        bus(1'b0, int_sched_pkg::STATUS_OFFSET, 32'h00000000);
        check(rd, 32'(expStat));
        @(posedge ref_clk);
        check(32'(irq), 32'h00000000);
    endtask

    // ****************************************
    // Microframe ticks, packet monitor, timeout
    // ****************************************
    always @(posedge ref_clk) begin
        cycles++;
        microframeTick <= rst_n && (cycles % 40 == 0);
        if (microframeTick === 1'b1) begin
            ticks++;
            ufPkts = 0;
        end
        if (pktReq === 1'b1 && !reqSeen) begin
            ufPkts++;
            maxPkts = (ufPkts > maxPkts) ? ufPkts : maxPkts;
            check(32'(pktLen), 32'((mRem < mMax) ? mRem : mMax));
            check(32'((mSel >> (ticks % 8)) & 1), 32'h00000001);
            check(32'(((ticks / 8) % 32) & smear(mInt)), 32'(mInt));
            check(32'(ufPkts <= mMult), 32'h00000001);
        end
        if (pktReq === 1'b1 && pktDone === 1'b1) mRem -= int'(pktActual);
        reqSeen = (pktReq === 1'b1);
        if (cycles == 90000) begin
            fails++;
            summarize();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int mult;
        int maxp;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        bus(1'b0, int_sched_pkg::DESC_CTRL_OFFSET, 32'h00000000);
        check(rd, 32'(int_sched_pkg::MULT_RESET) << int_sched_pkg::MULT_LSB);
        bus(1'b0, int_sched_pkg::DESC_POLL_OFFSET, 32'h00000000);
        check(rd, 32'(int_sched_pkg::SELMASK_RESET) << int_sched_pkg::SELMASK_LSB);
        bus(1'b0, 5'h14, 32'h00000000);
        check(rd, int_sched_pkg::UNMAPPED_READ);
        bus(1'b1, int_sched_pkg::MASK_OFFSET, 32'h00000003);
        bus(1'b0, int_sched_pkg::MASK_OFFSET, 32'h00000000);
        check(rd, 32'h00000003);
        mMask = 3;
        // Interval zero under four select masks, then one nonzero interval code for each period from 2 to 32 ms, with the multiplier cycling through its legal codes.
        for (int i = 0; i < 9; i++) begin
            seed = lfsr_next(seed);
            mult = 1 + i % 3;
            maxp = 2 + int'(seed[7:0]) % 23;
            run_xfer(mult, maxp, mult * maxp, intTab[i], selTab[i], mult * maxp, 1);
        end
        shortBy <= 11'h001;
        run_xfer(1, maxp, 3 * maxp, 0, 8'hFF, maxp - 1, 1);
        shortBy <= 11'h000;
        fatal <= 1'b1;
        bus(1'b1, int_sched_pkg::MASK_OFFSET, 32'h00000001);
        mMask = 1;
        run_xfer(2, maxp, 4 * maxp, 0, 8'hFF, -1, 2);
        fatal <= 1'b0;
        summarize();
    end
endmodule

`default_nettype wire
